//--- interval_time_counter.v
// interval time counter with time registers and special function registers
// How it works
// [R1] intervals from one 1/128 s tick to 256 hours
// [R2] everything runs on the crystal clock
// [R3] counting continues while core is powered down
// [R4] register accesses are taken on the crystal clock
// [R5] interval counter steps on selected register overflow
// [R6] compare match sets flag bit 2, interrupt
// [R7] enabled match in power-down wakes to vector
// [R8] time registers writable to preset current time
// [R9] six registers, control at A1, resets zero
// [R10] select 00 tick, 01 sec, 10 min, 11 hour
// [R11] single mode clears enable, else auto reload
// [R12] clock enable low stops, restores written values
// [R13] fraction counts 0..127 then steps seconds
`timescale 1ns/1ps
`include "interval_timer_regs.vh"
module interval_time_counter #(
	parameter XTAL_PER_TICK = `XTAL_PER_TICK
) (
	input wire ref_clk,
	input wire rst,
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata,
	output wire sfr_hit,
	input wire interval_int_enable,
	input wire power_down,
	output wire interval_irq,
	output wire wake_up,
	output wire [15:0] wake_vector
);
	reg [7:0] ctrl_r;
	reg [7:0] fraction_second_count;
	reg [7:0] sec_r;
	reg [7:0] min_r;
	reg [7:0] hour_r;
	reg [7:0] fraction_wr_r;
	reg [7:0] sec_wr_r;
	reg [7:0] min_wr_r;
	reg [7:0] hour_wr_r;
	reg [7:0] interval_compare_value;
	reg [7:0] interval_timer;
	reg pd_s1_r;
	reg pd_s2_r;
	reg ie_s1_r;
	reg ie_s2_r;
	wire tick;
	wire time_clock_enable = ctrl_r[`BIT_TIME_CLOCK_ENABLE];
	wire interval_count_enable = ctrl_r[`BIT_INTERVAL_COUNT_ENABLE];
	wire interval_match_flag = ctrl_r[`BIT_MATCH];
	wire single_interval_mode = ctrl_r[`BIT_SINGLE];
	wire [1:0] timebase_sel = {ctrl_r[`BIT_SEL_HI], ctrl_r[`BIT_SEL_LO]};
	wire hour24 = ctrl_r[`BIT_24H];
	wire [7:0] hour_max = hour24 ? `HOUR24_MAX : `HOUR_MAX;

	function sel;
		input [7:0] a;
		input [7:0] want;
		begin
			sel = (a == want);
		end
	endfunction

	// next value of a time register: wraps to zero on its own overflow
	function [7:0] wrap_inc;
		input [7:0] v;
		input wrap;
		begin
			wrap_inc = wrap ? 8'h00 : v + 8'h01;
		end
	endfunction

	tick_divider #(.DIV(XTAL_PER_TICK)) u_div ( // R2
		.ref_clk(ref_clk),
		.rst(rst),
		.run(time_clock_enable),
		.tick(tick)
	);

	// overflow chain of the time registers
	// a preset above the limit wraps at the next carry instead of at 255
	wire ov_frac = tick && fraction_second_count == `FRACTION_MAX; // R13
	wire ov_sec = ov_frac && sec_r >= `SEC_MAX;
	wire ov_min = ov_sec && min_r >= `MIN_MAX;
	wire ov_hour = ov_min && hour_r >= hour_max;
	reg step;
	always @* begin
		case (timebase_sel) // R10
			`SEL_FRACTION: step = tick;
			`SEL_SECONDS: step = ov_frac;
			`SEL_MINUTES: step = ov_sec;
			`SEL_HOURS: step = ov_min;
			default: step = 1'b0;
		endcase
	end
	// step the interval counter on the chosen overflow
	wire istep = step && interval_count_enable && time_clock_enable; // R5
	wire [7:0] inext = interval_timer + 8'h01;
	wire match = istep && inext == interval_compare_value; // R6 R1

	// register write strobes, one per address
	wire wr_ctrl = sfr_wr && sel(sfr_addr, `ADDR_CONTROL); // R4
	wire wr_cmp = sfr_wr && sel(sfr_addr, `ADDR_COMPARE);
	wire time_wr_ok = sfr_wr && !time_clock_enable; // R12
	wire wr_frac = time_wr_ok && sel(sfr_addr, `ADDR_FRACTION); // R8
	wire wr_sec = time_wr_ok && sel(sfr_addr, `ADDR_SECONDS);
	wire wr_min = time_wr_ok && sel(sfr_addr, `ADDR_MINUTES);
	wire wr_hour = time_wr_ok && sel(sfr_addr, `ADDR_HOURS);
	// bit 7 is not implemented and always reads back as zero
	wire [7:0] ctrl_wr_val = {1'b0, sfr_wdata[6:0]};
	wire [7:0] frac_wr_val = {1'b0, sfr_wdata[6:0]};

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= `CTRL_RESET; // R9
			interval_compare_value <= 8'h00;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= ctrl_wr_val;
				// a match landing on a clearing write keeps the flag
				if (match)
					ctrl_r[`BIT_MATCH] <= 1'b1;
			end else if (match) begin
				ctrl_r[`BIT_MATCH] <= 1'b1; // R6
				if (single_interval_mode)
					ctrl_r[`BIT_INTERVAL_COUNT_ENABLE] <= 1'b0; // R11
			end
			if (wr_cmp)
				interval_compare_value <= sfr_wdata;
		end
	end

	// counter restarts from zero when disabled or after timeout
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			interval_timer <= 8'h00;
		else if (!interval_count_enable || match)
			interval_timer <= 8'h00; // R11
		else if (istep)
			interval_timer <= inext;
	end

	// time registers; shadow copies hold the last software write
	// a write also lands in the live register at once, so a read
	// right behind it already returns the new value
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fraction_second_count <= 8'h00;
			sec_r <= 8'h00;
			min_r <= 8'h00;
			hour_r <= 8'h00;
			fraction_wr_r <= 8'h00;
			sec_wr_r <= 8'h00;
			min_wr_r <= 8'h00;
			hour_wr_r <= 8'h00;
		end else if (!time_clock_enable) begin
			if (wr_frac)
				fraction_wr_r <= frac_wr_val; // R8
			if (wr_sec)
				sec_wr_r <= sfr_wdata;
			if (wr_min)
				min_wr_r <= sfr_wdata;
			if (wr_hour)
				hour_wr_r <= sfr_wdata;
			fraction_second_count <= wr_frac ? frac_wr_val :
				fraction_wr_r; // R12
			sec_r <= wr_sec ? sfr_wdata : sec_wr_r;
			min_r <= wr_min ? sfr_wdata : min_wr_r;
			hour_r <= wr_hour ? sfr_wdata : hour_wr_r;
		end else if (tick) begin
			fraction_second_count <= wrap_inc(fraction_second_count,
				ov_frac); // R13
			if (ov_frac)
				sec_r <= wrap_inc(sec_r, ov_sec);
			if (ov_sec)
				min_r <= wrap_inc(min_r, ov_min);
			if (ov_min)
				hour_r <= wrap_inc(hour_r, ov_hour);
		end
	end

	// read data registered; unmapped reads give zero
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			sfr_rdata <= 8'h00;
		else if (sfr_rd) begin
			case (sfr_addr)
				`ADDR_CONTROL: sfr_rdata <= ctrl_r;
				`ADDR_FRACTION: sfr_rdata <= fraction_second_count;
				`ADDR_SECONDS: sfr_rdata <= sec_r;
				`ADDR_MINUTES: sfr_rdata <= min_r;
				`ADDR_HOURS: sfr_rdata <= hour_r;
				`ADDR_COMPARE: sfr_rdata <= interval_compare_value;
				default: sfr_rdata <= 8'h00;
			endcase
		end
	end
	// hit lets the core's register decoder route the six addresses here
	assign sfr_hit = sfr_addr >= `ADDR_CONTROL && sfr_addr <= `ADDR_COMPARE;

	// core-side levels come from another domain
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pd_s1_r <= 1'b0;
			pd_s2_r <= 1'b0;
			ie_s1_r <= 1'b0;
			ie_s2_r <= 1'b0;
		end else begin
			pd_s1_r <= power_down;
			pd_s2_r <= pd_s1_r;
			ie_s1_r <= interval_int_enable;
			ie_s2_r <= ie_s1_r;
		end
	end
	// counting ignores power_down entirely so long sleeps are timed
	// the flag is a level that the core clears by writing bit 2 low
	assign interval_irq = interval_match_flag && ie_s2_r; // R6 R3
	assign wake_up = interval_irq && pd_s2_r; // R7
	assign wake_vector = `WAKE_VECTOR; // R7
endmodule

//--- interval_timer_regs.vh
// register offsets, field positions and timing counts of the interval counter
`ifndef INTERVAL_TIMER_REGS_VH
`define INTERVAL_TIMER_REGS_VH
`define ADDR_CONTROL 8'hA1
`define ADDR_FRACTION 8'hA2
`define ADDR_SECONDS 8'hA3
`define ADDR_MINUTES 8'hA4
`define ADDR_HOURS 8'hA5
`define ADDR_COMPARE 8'hA6
`define CTRL_RESET 8'h00
`define BIT_TIME_CLOCK_ENABLE 0
`define BIT_INTERVAL_COUNT_ENABLE 1
`define BIT_MATCH 2
`define BIT_SINGLE 3
`define BIT_SEL_LO 4
`define BIT_SEL_HI 5
`define BIT_24H 6
`define FRACTION_MAX 8'h7F
`define SEC_MAX 8'h3B
`define MIN_MAX 8'h3B
`define HOUR24_MAX 8'h17
`define HOUR_MAX 8'hFF
`define SEL_FRACTION 2'h0
`define SEL_SECONDS 2'h1
`define SEL_MINUTES 2'h2
`define SEL_HOURS 2'h3
`define WAKE_VECTOR 16'h0053
`define XTAL_HZ 32768
`define TICK_HZ 128
`define XTAL_PER_TICK (`XTAL_HZ / `TICK_HZ)
`endif

//--- tick_divider.v
// divider making one-cycle 1/128 s tick enables from the crystal clock
`timescale 1ns/1ps
module tick_divider #(
	parameter DIV = 256
) (
	input wire ref_clk,
	input wire rst,
	input wire run,
	output reg tick
);
	reg [15:0] cnt_r;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 16'h0000;
			tick <= 1'b0;
		end else if (!run) begin
			// stopping clears the phase so a restart gives a full first tick
			cnt_r <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt_r == DIV - 1) begin
			cnt_r <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule

//--- interval_time_counter_sva.sv
// port assertions for the interval time counter
`timescale 1ns/1ps
module interval_time_counter_sva (
	input wire ref_clk,
	input wire rst,
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata,
	input wire sfr_hit,
	input wire interval_int_enable,
	input wire power_down,
	input wire interval_irq,
	input wire wake_up,
	input wire [15:0] wake_vector
);
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
a_vector_const: assert property (
	wake_vector == 16'h0053) else $error("vector");
a_hit_decode: assert property (
	sfr_hit == (sfr_addr >= 8'hA1 && sfr_addr <= 8'hA6)) else $error("hit");
a_ctrl_bit7: assert property (
	sfr_rd && sfr_addr == 8'hA1 |=> !sfr_rdata[7]) else $error("bit7");
a_unmapped_zero: assert property (
	sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00) else $error("unmapped");
a_ctrl_readback: assert property (
	sfr_wr && sfr_addr == 8'hA1 ##1 !sfr_wr ##1 sfr_rd && sfr_addr == 8'hA1
	|=> sfr_rdata[6:4] == $past(sfr_wdata[6:4], 3)) else $error("ctrl");
a_irq_needs_en: assert property (
	interval_irq |-> $past(interval_int_enable, 2)) else $error("irq");
a_wake_rule: assert property (
	wake_up == (interval_irq && $past(power_down, 2))) else $error("wake");
a_rdata_hold: assert property (
	!$past(sfr_rd) && !$past(rst) |-> $stable(sfr_rdata)) else $error("hold");
endmodule
bind interval_time_counter interval_time_counter_sva interval_time_counter_sva_inst (
	.ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
	.sfr_hit, .interval_int_enable, .power_down, .interval_irq, .wake_up,
	.wake_vector);

//--- core_model.sv
// core-side model issuing register accesses
`timescale 1ns/1ps
module core_model (
	input wire ref_clk,
	output reg [7:0] sfr_addr = 8'h00,
	output reg sfr_wr = 1'b0,
	output reg sfr_rd = 1'b0,
	output reg [7:0] sfr_wdata = 8'h00,
	output reg interval_int_enable = 1'b0,
	output reg power_down = 1'b0
);
// idle cycle after each access gives the slow clock time to finish it
task acc(input [7:0] a, input [7:0] d, input w);
	begin
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= w;
		sfr_rd <= !w;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b0;
		sfr_addr <= ~a;
		sfr_wdata <= ~d;
		@(posedge ref_clk);
	end
endtask
endmodule

//--- tb_interval_time_counter.sv
// self-checking bench for the interval time counter
`timescale 1ns/1ps
module tb_interval_time_counter;
reg ref_clk = 1'b0;
reg rst = 1'b1;
reg rd_d = 1'b0;
wire [7:0] sfr_addr, sfr_wdata, sfr_rdata;
wire [15:0] wake_vector;
wire sfr_wr, sfr_rd, sfr_hit, interval_int_enable, power_down;
wire interval_irq, wake_up;
integer miscompares = 0;
integer samples_checked = 0;
integer seed = 30234;
reg [7:0] exp_q[$];
reg [7:0] hr;
reg [7:0] c;
reg [7:0] sc;
reg [7:0] mn;
integer s;
core_model core_model_inst (.ref_clk, .sfr_addr, .sfr_wr, .sfr_rd,
	.sfr_wdata, .interval_int_enable, .power_down);
interval_time_counter #(.XTAL_PER_TICK(4)) interval_time_counter_inst (
	.ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
	.sfr_hit, .interval_int_enable, .power_down, .interval_irq, .wake_up,
	.wake_vector);
initial forever #12.5 ref_clk = ~ref_clk;
task chk(input [7:0] got, input [7:0] want);
	begin
		samples_checked++;
		if (got !== want) begin
			miscompares++;
			$display("ERROR %0t: got %h want %h", $time, got, want);
		end
	end
endtask
task final_report;
	begin
		$display("checks %0d errors %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
endtask
task rd(input [7:0] a, input [7:0] want);
	begin
		exp_q.push_back(want);
		core_model_inst.acc(a, 8'h00, 1'b0);
	end
endtask
task wr(input [7:0] a, input [7:0] d);
	core_model_inst.acc(a, d, 1'b1);
endtask
// stop the time clock and load fraction, seconds and minutes
task preset(input [7:0] f, input [7:0] sv, input [7:0] mv);
	begin
		wr(8'hA1, 8'h00);
		wr(8'hA2, f);
		wr(8'hA3, sv);
		wr(8'hA4, mv);
	end
endtask
task wait_irq;
	integer n;
	begin
		n = 0;
		while (interval_irq !== 1'b1 && n < 40) begin
			@(posedge ref_clk);
			n++;
		end
		chk({7'h00, interval_irq}, 8'h01);
	end
endtask
always @(posedge ref_clk) rd_d <= sfr_rd;
always @(negedge ref_clk) if (rd_d) chk(sfr_rdata, exp_q.pop_front());
initial begin
	repeat (3) @(posedge ref_clk);
	rst <= 1'b0;
	rd(8'hA1, 8'h00);
	rd(8'hA0, 8'h00);
	hr = 8'h17 & $random(seed);
	wr(8'hA5, hr);
	wr(8'hA2, 8'h7E);
	rd(8'hA5, hr);
	wr(8'hA6, 8'h02);
	core_model_inst.interval_int_enable <= 1'b1;
	wr(8'hA1, 8'h03);
	rd(8'hA1, 8'h03);
	wait_irq;
	core_model_inst.power_down <= 1'b1;
	repeat (3) @(posedge ref_clk);
	chk({7'h00, wake_up}, 8'h01);
	wr(8'hA1, 8'h00);
	rd(8'hA2, 8'h7E);
	chk({7'h00, interval_irq}, 8'h00);
	// fraction 7E reaches rollover within two ticks, seconds 3B wrap
	wr(8'hA3, 8'h3B);
	wr(8'hA1, 8'h01);
	repeat (16) @(posedge ref_clk);
	rd(8'hA4, 8'h01);
	wr(8'hA1, 8'h0B);
	wait_irq;
	rd(8'hA1, 8'h0D);
	// seconds, minutes and hours timebases: a preset one level short must not step the counter,
	// a preset reaching the chosen level must step it on the second tick
	for (s = 1; s < 4; s = s + 1) begin
		c = {2'b01, s[1:0], 4'hB};
		sc = (s > 1) ? 8'h3B : 8'h00;
		mn = (s > 2) ? 8'h3B : 8'h00;
		preset(sc ? 8'h7E : 8'h00, mn, 8'h00);
		wr(8'hA5, 8'h17);
		wr(8'hA6, 8'h01);
		wr(8'hA1, c);
		repeat (12) @(posedge ref_clk);
		chk({7'h00, interval_irq}, 8'h00);
		preset(8'h7E, sc, mn);
		wr(8'hA1, c);
		wait_irq;
		rd(8'hA2, 8'h00);
		rd(8'hA5, mn ? 8'h00 : 8'h17);
		rd(8'hA1, c ^ 8'h06);
	end
	final_report;
end
initial begin
	#(25 * 4000);
	miscompares++;
	final_report;
end
endmodule
